// ### fan_ctrl_pkg.sv
// Shared constants and types for the fan mode configuration and alert gating block.
package fan_ctrl_pkg;

    // Register byte addresses on the serial port.
    localparam logic [7:0] ADDR_CFG    = 8'h00;
    localparam logic [7:0] ADDR_DUTY   = 8'h22;
    localparam logic [7:0] ADDR_TGT_LO = 8'h1E;
    localparam logic [7:0] ADDR_TGT_HI = 8'h1F;
    localparam logic [7:0] ADDR_SPARE_A = 8'h3A;
    localparam logic [7:0] ADDR_SPARE_B = 8'h3B;

    // Values after reset.
    localparam logic [7:0] CFG_RESET   = 8'hD4;
    localparam logic [7:0] DUTY_RESET  = 8'h00;
    localparam logic [7:0] TGT_RESET   = 8'hFF;
    localparam logic [7:0] SPARE_VALUE = 8'h00;
    localparam logic [7:0] PTR_RESET   = 8'h00;

    // Field positions inside the primary configuration register.
    localparam int BIT_OT_IE     = 7;
    localparam int BIT_DRV_HI    = 6;
    localparam int BIT_DRV_LO    = 5;
    localparam int BIT_FAULT_EN  = 4;
    localparam int BIT_POLARITY  = 3;
    localparam int BIT_FAN_IE    = 2;
    localparam int BIT_ALERT_EN  = 1;
    localparam int BIT_START     = 0;

    // Serial framing counts: eight data bits, then the acknowledge slot.
    localparam logic [3:0] LAST_DATA_BIT = 4'h7;
    localparam logic [3:0] ACK_SLOT      = 4'h8;

    // Fan drive selector encodings.
    typedef enum logic [1:0] {
        MODE_DIRECT = 2'b00,
        MODE_SPEED  = 2'b01,
        MODE_REMOTE = 2'b10,
        MODE_MAX    = 2'b11
    } fan_mode_t;

    // Byte phases of a serial transaction.
    typedef enum logic [2:0] {
        PH_IDLE,
        PH_ADDR,
        PH_PTR,
        PH_WDATA,
        PH_RDATA
    } phase_t;

endpackage : fan_ctrl_pkg

// ### sync_2ff.sv
// Two flip-flop synchroniser for levels entering a clock domain.
`timescale 1ns/1ps
module sync_2ff #(
    parameter int               WIDTH     = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input  wire logic             clk,
    input  wire logic             rst_b,
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);

    logic [WIDTH-1:0] meta_q;

    // The first stage feeds the second stage only, never any logic.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            meta_q <= RESET_VAL;
            dout   <= RESET_VAL;
        end else begin
            meta_q <= din;
            dout   <= meta_q;
        end
    end

endmodule : sync_2ff

// ### scl_bit_capture.sv
// Serial clock domain front end: samples the data line on each rising clock edge.
`timescale 1ns/1ps
module scl_bit_capture (
    input  wire logic sclClk,
    input  wire logic rst_b,
    input  wire logic sdaIn,
    output logic      bitVal,
    output logic      bitToggle
);

    logic rstLink_b;

    // The system reset is brought into the serial clock domain as a level.
    sync_2ff #(
        .WIDTH     (1),
        .RESET_VAL (1'b0)
    ) u_rstSync (
        .clk   (sclClk),
        .rst_b (1'b1),
        .din   (rst_b),
        .dout  (rstLink_b)
    );

    // Each edge flips the toggle; the bit stays stable until the next edge,
    // long enough for the system side to read it after seeing the toggle.
    always_ff @(posedge sclClk) begin
        if (!rstLink_b) begin
            bitVal    <= 1'b1;
            bitToggle <= 1'b0;
        end else begin
            bitVal    <= sdaIn;
            bitToggle <= ~bitToggle;
        end
    end

endmodule : scl_bit_capture

// ### fan_cfg_alert.sv
// Fan mode configuration, alert gating and serial register port of the fan controller.
`timescale 1ns/1ps
module fan_cfg_alert #(
    parameter logic [6:0] DEV_ADDR = 7'h18
) (
    input  wire logic                  clk_sys,
    input  wire logic                  rst_b,
    input  wire logic                  sclClk,
    input  wire logic                  sdaIn,
    output logic                       sdaOut,
    output logic                       sdaOe,
    input  wire logic                  localOvertempFlag,
    input  wire logic                  remoteOvertempFlag,
    input  wire logic                  fanStallFlag,
    input  wire logic                  speedRangeAlarm,
    input  wire logic                  fanFaultIn,
    input  wire logic                  pwmActive,
    input  wire logic [7:0]            remoteDuty,
    input  wire logic [7:0]            localDuty,
    input  wire logic [7:0]            speedLoopDuty,
    output logic                       pwmOut,
    output logic                       pwmOutOe,
    output logic                       fanFaultOut,
    output logic                       fanFaultOe,
    output logic                       overtempOutputPinOut,
    output logic                       overtempOutputPinOe,
    output logic                       alertOut,
    output logic                       alertOe,
    output logic                       fanOutOfRangeIrq,
    output fan_ctrl_pkg::fan_mode_t    fanMode,
    output logic [7:0]                 pwmDuty,
    output logic [15:0]                speedTarget,
    output logic                       monitorEn
);

    import fan_ctrl_pkg::*;

    logic [1:0]  pinSync;
    logic        sclS;
    logic        sdaS;
    logic        sdaPrev_q;
    logic        startEv;
    logic        stopEv;
    logic        linkBit;
    logic        linkTgl;
    logic        tglS;
    logic        tglPrev_q;
    logic        bitEv;
    phase_t      phase_q;
    phase_t      phaseAck;
    logic [3:0]  bitCnt_q;
    logic [7:0]  shift_q;
    logic [7:0]  rxByte;
    logic        lastBit;
    logic        slotEnd;
    logic        ackPend_q;
    logic        rw_q;
    logic [7:0]  ptr_q;
    logic [7:0]  rdByte_q;
    logic        wrEn;
    logic [7:0]  cfg_q;
    logic [7:0]  duty_q;
    logic [7:0]  tgtLo_q;
    logic [7:0]  tgtHi_q;
    fan_mode_t   modeSel;
    fan_mode_t   modeEff;
    logic [7:0]  maxDuty;
    logic        otIrq;
    logic        fanIrq;

    // Register read multiplexer; unmapped and spare addresses read zero.
    function automatic logic [7:0] regRead(input logic [7:0] a);
        logic [7:0] v;
        v = SPARE_VALUE;
        if (a == ADDR_CFG) begin
            v = cfg_q;
        end else if (a == ADDR_DUTY) begin
            v = duty_q;
        end else if (a == ADDR_TGT_LO) begin
            v = tgtLo_q;
        end else if (a == ADDR_TGT_HI) begin
            v = tgtHi_q;
        end
        return v;
    endfunction : regRead

    // Pin levels for start and stop detection pass two flip-flops first.
    sync_2ff #(
        .WIDTH     (2),
        .RESET_VAL (2'b11)
    ) u_pinSync (
        .clk   (clk_sys),
        .rst_b (rst_b),
        .din   ({sclClk, sdaIn}),
        .dout  (pinSync)
    );

    assign sclS = pinSync[1];
    assign sdaS = pinSync[0];

    // Data bits are captured on the serial clock itself.
    scl_bit_capture u_link (
        .sclClk    (sclClk),
        .rst_b     (rst_b),
        .sdaIn     (sdaIn),
        .bitVal    (linkBit),
        .bitToggle (linkTgl)
    );

    // The toggle is the event; the bit it marks is held stable meanwhile.
    sync_2ff #(
        .WIDTH     (1),
        .RESET_VAL (1'b0)
    ) u_tglSync (
        .clk   (clk_sys),
        .rst_b (rst_b),
        .din   (linkTgl),
        .dout  (tglS)
    );

    // Previous synchronised levels for edge detection.
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            sdaPrev_q <= 1'b1;
            tglPrev_q <= 1'b0;
        end else begin
            sdaPrev_q <= sdaS;
            tglPrev_q <= tglS;
        end
    end

    // A data change while the clock is high frames the transaction.
    assign startEv = sclS & sdaPrev_q & ~sdaS;
    assign stopEv  = sclS & ~sdaPrev_q & sdaS;
    assign bitEv   = (tglS ^ tglPrev_q) && (phase_q != PH_IDLE);
    assign rxByte  = {shift_q[6:0], linkBit};
    assign lastBit = bitEv && (bitCnt_q == LAST_DATA_BIT);
    assign slotEnd = bitEv && (bitCnt_q == ACK_SLOT);
    assign wrEn    = lastBit && (phase_q == PH_WDATA);

    // Phase that follows an acknowledge slot; a master refusal ends a read.
    always_comb begin
        phaseAck = PH_IDLE;
        case (phase_q)
            PH_ADDR:  phaseAck = ackPend_q ? (rw_q ? PH_RDATA : PH_PTR) : PH_IDLE;
            PH_PTR:   phaseAck = PH_WDATA;
            PH_WDATA: phaseAck = PH_WDATA;
            PH_RDATA: phaseAck = linkBit ? PH_IDLE : PH_RDATA;
            default:  phaseAck = PH_IDLE;
        endcase
    end

    // Byte phase and bit position; start and stop override everything.
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            phase_q  <= PH_IDLE;
            bitCnt_q <= 4'h0;
        end else if (startEv) begin
            phase_q  <= PH_ADDR;
            bitCnt_q <= 4'h0;
        end else if (stopEv) begin
            phase_q  <= PH_IDLE;
            bitCnt_q <= 4'h0;
        end else if (slotEnd) begin
            phase_q  <= phaseAck;
            bitCnt_q <= 4'h0;
        end else if (bitEv) begin
            bitCnt_q <= bitCnt_q + 4'h1;
        end
    end

    // Incoming bits shift in most significant first.
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            shift_q <= 8'h00;
        end else if (bitEv) begin
            shift_q <= rxByte;
        end
    end

    // Acknowledge decision and transfer direction, fixed after the eighth bit.
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            ackPend_q <= 1'b0;
            rw_q      <= 1'b0;
        end else if (startEv || slotEnd) begin
            ackPend_q <= 1'b0;
        end else if (lastBit) begin
            if (phase_q == PH_ADDR) begin
                ackPend_q <= (rxByte[7:1] == DEV_ADDR);
                rw_q      <= rxByte[0];
            end else begin
                ackPend_q <= (phase_q != PH_RDATA);
            end
        end
    end

    // Register pointer, advanced after each written or acknowledged read byte.
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            ptr_q <= PTR_RESET;
        end else if (lastBit && (phase_q == PH_PTR)) begin
            ptr_q <= rxByte;
        end else if (slotEnd && (phase_q == PH_WDATA)) begin
            ptr_q <= ptr_q + 8'h01;
        end else if (slotEnd && (phase_q == PH_RDATA) && !linkBit) begin
            ptr_q <= ptr_q + 8'h01;
        end
    end

    // Read data is loaded at the slot before it goes out, then shifted.
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            rdByte_q <= 8'h00;
        end else if (slotEnd && (phase_q == PH_ADDR)) begin
            rdByte_q <= regRead(ptr_q);
        end else if (slotEnd && (phase_q == PH_RDATA)) begin
            rdByte_q <= regRead(ptr_q + 8'h01);
        end else if (bitEv && (phase_q == PH_RDATA) && (bitCnt_q < ACK_SLOT)) begin
            rdByte_q <= {rdByte_q[6:0], 1'b0};
        end
    end

    // The data line is only ever pulled low; a one is a released line.
    assign sdaOut = 1'b0;
    assign sdaOe  = ((bitCnt_q == ACK_SLOT) && ackPend_q)
                 || ((phase_q == PH_RDATA) && (bitCnt_q < ACK_SLOT) && !rdByte_q[7]);

    // Primary configuration register.
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            cfg_q <= CFG_RESET;
        end else if (wrEn && (ptr_q == ADDR_CFG)) begin
            cfg_q <= rxByte;
        end
    end

    // Direct duty register written by the host.
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            duty_q <= DUTY_RESET;
        end else if (wrEn && (ptr_q == ADDR_DUTY)) begin
            duty_q <= rxByte;
        end
    end

    // Speed target halves; the spare addresses take no write.
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            tgtLo_q <= TGT_RESET;
            tgtHi_q <= TGT_RESET;
        end else if (wrEn && (ptr_q == ADDR_TGT_LO)) begin
            tgtLo_q <= rxByte;
        end else if (wrEn && (ptr_q == ADDR_TGT_HI)) begin
            tgtHi_q <= rxByte;
        end
    end

    assign speedTarget = {tgtHi_q, tgtLo_q};
    assign monitorEn   = cfg_q[BIT_START];

    // Without the start bit the loops have no measurements, so direct wins.
    assign modeSel = fan_mode_t'(cfg_q[BIT_DRV_HI:BIT_DRV_LO]);
    assign modeEff = cfg_q[BIT_START] ? modeSel : MODE_DIRECT;
    assign maxDuty = (remoteDuty > localDuty) ? remoteDuty : localDuty;

    // Duty handed to the waveform generator, one cycle behind its sources.
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            fanMode <= MODE_DIRECT;
            pwmDuty <= DUTY_RESET;
        end else begin
            fanMode <= modeEff;
            case (modeEff)
                MODE_MAX:    pwmDuty <= maxDuty;
                MODE_REMOTE: pwmDuty <= remoteDuty;
                MODE_SPEED:  pwmDuty <= speedLoopDuty;
                default:     pwmDuty <= duty_q;
            endcase
        end
    end

    // Enabled sources; both share the one alert pin.
    assign otIrq  = cfg_q[BIT_OT_IE] & (localOvertempFlag | remoteOvertempFlag);
    assign fanIrq = cfg_q[BIT_FAN_IE] & (fanStallFlag | speedRangeAlarm);

    // Open-drain pins are driven low through their enables only.
    assign pwmOut               = 1'b0;
    assign fanFaultOut          = 1'b0;
    assign overtempOutputPinOut = 1'b0;
    assign alertOut             = 1'b0;

    // The fan, overtemp and alert pin enables are registered so those pads never see decode glitches.
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            pwmOutOe            <= 1'b0;
            fanFaultOe          <= 1'b0;
            overtempOutputPinOe <= 1'b0;
            alertOe             <= 1'b0;
            fanOutOfRangeIrq    <= 1'b0;
        end else begin
            pwmOutOe            <= cfg_q[BIT_POLARITY] ? ~pwmActive : pwmActive;
            fanFaultOe          <= cfg_q[BIT_FAULT_EN] & fanFaultIn;
            overtempOutputPinOe <= localOvertempFlag | remoteOvertempFlag;
            alertOe             <= cfg_q[BIT_ALERT_EN] & (otIrq | fanIrq);
            fanOutOfRangeIrq    <= fanIrq;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    a_cfg_reset_value: assert property (disable iff (1'b0) !rst_b |=> cfg_q == CFG_RESET)
        else $error("configuration register did not reset to its default");

    a_alert_needs_enable: assert property (alertOe |-> $past(cfg_q[BIT_ALERT_EN]) && $past(otIrq || fanIrq))
        else $error("alert driven without enable and active source");

    a_ot_alert_raise: assert property (cfg_q[BIT_ALERT_EN] && cfg_q[BIT_OT_IE]
                                       && (localOvertempFlag || remoteOvertempFlag) |=> alertOe)
        else $error("over-temperature did not raise the alert");

    a_ot_pin_masked: assert property (!cfg_q[BIT_OT_IE] && !fanIrq && remoteOvertempFlag
                                      |=> !alertOe && overtempOutputPinOe)
        else $error("masked over-temperature handled wrongly");

    a_fan_irq_raise: assert property (cfg_q[BIT_ALERT_EN] && cfg_q[BIT_FAN_IE]
                                      && (fanStallFlag || speedRangeAlarm) |=> alertOe && fanOutOfRangeIrq)
        else $error("fan speed event did not raise the alert");

    a_alert_global_off: assert property (!cfg_q[BIT_ALERT_EN] [*2] |-> !alertOe)
        else $error("alert driven while globally disabled");

    a_mode_select: assert property (cfg_q[BIT_START] |=> fanMode == $past(cfg_q[BIT_DRV_HI:BIT_DRV_LO]))
        else $error("fan mode does not follow the drive selector");

    a_max_duty: assert property (modeEff == MODE_MAX |=> pwmDuty >= $past(remoteDuty)
                                 && pwmDuty >= $past(localDuty))
        else $error("max mode duty below a computed duty");

    a_remote_duty: assert property (modeEff == MODE_REMOTE |=> pwmDuty == $past(remoteDuty))
        else $error("remote mode duty mismatch");

    a_direct_duty: assert property (modeEff == MODE_DIRECT |=> pwmDuty == $past(duty_q))
        else $error("direct mode duty mismatch");

    a_speed_duty: assert property (modeEff == MODE_SPEED |=> pwmDuty == $past(speedLoopDuty))
        else $error("speed mode duty mismatch");

    a_start_gate: assert property (!cfg_q[BIT_START] |=> fanMode == MODE_DIRECT)
        else $error("closed loop mode active without start bit");

    a_fault_hiz: assert property (!cfg_q[BIT_FAULT_EN] |=> !fanFaultOe)
        else $error("fan failure pin driven while disabled");

    a_pwm_polarity: assert property (pwmActive && $stable(cfg_q) |=> pwmOutOe == !$past(cfg_q[BIT_POLARITY]))
        else $error("pwm pin polarity wrong at full on time");

    c_cfg_write: cover property (wrEn && (ptr_q == ADDR_CFG));
    c_read_byte: cover property (slotEnd && (phase_q == PH_RDATA));
    c_max_mode: cover property (modeEff == MODE_MAX);
    c_alert_on: cover property ($rose(alertOe));

endmodule : fan_cfg_alert

// ### serial_host_model.sv
// Behavioural serial bus host that drives the register port of the fan controller.
`timescale 1ns/1ps
module serial_host_model #(
    parameter logic [6:0] DEV_ADDR = 7'h18
) (
    output logic      sclClk,
    output logic      sdaHostLow,
    input  wire logic sdaWire
);
    // Between frames the clock stands high and the data line is left to its pull-up.
    initial begin
        sclClk     = 1'b1;
        sdaHostLow = 1'b0;
    end

    // Clock pulses with data released around reset, so the link reset takes hold and then lets go.
    task automatic resetClocks();
        repeat (4) begin
            #40 sclClk = 1'b0;
            #40 sclClk = 1'b1;
        end
    endtask : resetClocks

    // Start or repeated start: data falls while the clock is high.
    task automatic startCond();
        #20 sdaHostLow = 1'b0;
        #40 sclClk = 1'b1;
        #40 sdaHostLow = 1'b1;
        #40 sclClk = 1'b0;
    endtask : startCond

    // Stop: data rises while the clock is high, then the clock stands still.
    task automatic stopCond();
        #20 sdaHostLow = 1'b1;
        #60 sclClk = 1'b1;
        #40 sdaHostLow = 1'b0;
        #40;
    endtask : stopCond

    // One 80 ns slot: data changes halfway through the low phase, the wire is read at the rising edge.
    task automatic slot(input logic drvLow, output logic seen);
        #20 sdaHostLow = drvLow;
        #20 sclClk = 1'b1;
        #1 seen = sdaWire;
        #39 sclClk = 1'b0;
    endtask : slot

    // Eight bits most significant first, then the device's acknowledge slot.
    task automatic sendByte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            slot(~b[i], s);
        end
        slot(1'b0, s);
        ack = ~s;
    endtask : sendByte

    // Eight bits from the device; the last byte is refused so the device lets go.
    task automatic recvByte(input logic last, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            slot(1'b0, s);
            b[i] = s;
        end
        slot(~last, s);
    endtask : recvByte

    // Register write: address, pointer, one data byte.
    task automatic writeReg(input logic [7:0] addr, input logic [7:0] data, output logic ok);
        logic a0, a1, a2;
        // Link edges stay a few ns away from the system clock edges.
        #5;
        startCond();
        sendByte({DEV_ADDR, 1'b0}, a0);
        sendByte(addr, a1);
        sendByte(data, a2);
        stopCond();
        ok = a0 & a1 & a2;
    endtask : writeReg

    // Register read: pointer write, repeated start, one byte ended by a refusal.
    task automatic readReg(input logic [7:0] addr, output logic [7:0] data, output logic ok);
        logic a0, a1, a2;
        // Link edges stay a few ns away from the system clock edges.
        #5;
        startCond();
        sendByte({DEV_ADDR, 1'b0}, a0);
        sendByte(addr, a1);
        startCond();
        sendByte({DEV_ADDR, 1'b1}, a2);
        recvByte(1'b1, data);
        stopCond();
        ok = a0 & a1 & a2;
    endtask : readReg
endmodule : serial_host_model

// ### fan_mode_config_and_alert_gating_test.sv
// Self-checking testbench for the fan mode configuration and alert gating block.
`timescale 1ns/1ps
module fan_mode_config_and_alert_gating_test;
    import fan_ctrl_pkg::*;
    logic        clk_sys, rst_b, sclClk, sdaHostLow, sdaWire;
    logic        otLocal, otRemote, stall, rangeAlarm, faultIn, pwmOn;
    logic [7:0]  dutyRem, dutyLoc, dutySpd, pwmDuty, cfgM, dutyM;
    logic        sdaOe, pwmOutOe, fanFaultOe, otOe, alertOe, fanIrq, monitorEn;
    logic        sdaLvl, pwmLvl, faultLvl, otLvl, alertLvl;
    fan_mode_t   fanMode;
    logic [15:0] speedTarget, tgtM;
    logic [31:0] rng;
    int          n_fail, samples_checked;

    // Open-drain data line: anyone pulling low wins, otherwise the pull-up holds it high.
    assign sdaWire = ~(sdaHostLow | sdaOe);

    fan_cfg_alert fan_cfg_alert_inst (
        .clk_sys(clk_sys), .rst_b(rst_b), .sclClk(sclClk), .sdaIn(sdaWire), .sdaOut(sdaLvl), .sdaOe(sdaOe),
        .localOvertempFlag(otLocal), .remoteOvertempFlag(otRemote), .fanStallFlag(stall),
        .speedRangeAlarm(rangeAlarm), .fanFaultIn(faultIn), .pwmActive(pwmOn), .remoteDuty(dutyRem),
        .localDuty(dutyLoc), .speedLoopDuty(dutySpd), .pwmOut(pwmLvl), .pwmOutOe(pwmOutOe),
        .fanFaultOut(faultLvl), .fanFaultOe(fanFaultOe), .overtempOutputPinOut(otLvl),
        .overtempOutputPinOe(otOe), .alertOut(alertLvl),
        .alertOe(alertOe), .fanOutOfRangeIrq(fanIrq), .fanMode(fanMode), .pwmDuty(pwmDuty),
        .speedTarget(speedTarget), .monitorEn(monitorEn));

    serial_host_model serial_host_model_inst (.sclClk(sclClk), .sdaHostLow(sdaHostLow), .sdaWire(sdaWire));

    // System clock at 50 MHz.
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xorshift

    // Without the start bit only the direct mode can run.
    function automatic logic [1:0] expMode(input logic [7:0] c);
        return c[BIT_START] ? c[6:5] : 2'b00;
    endfunction : expMode

    function automatic logic [7:0] expDuty(input logic [1:0] m);
        case (m)
            2'b00:   return dutyM;
            2'b01:   return dutySpd;
            2'b10:   return dutyRem;
            default: return (dutyRem > dutyLoc) ? dutyRem : dutyLoc;
        endcase
    endfunction : expDuty

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic chkBit(input logic got, input logic exp, input string what);
        chk({15'h0, got}, {15'h0, exp}, what);
    endtask : chkBit

    // Pins are registered, so three edges after the inputs moved everything has landed.
    task automatic checkPins();
        logic fanExp;
        repeat (3) @(posedge clk_sys);
        #1;
        fanExp = cfgM[2] & (stall | rangeAlarm);
        chk({14'h0, fanMode}, {14'h0, expMode(cfgM)}, "mode");
        chk({8'h0, pwmDuty}, {8'h0, expDuty(expMode(cfgM))}, "duty");
        chkBit(alertOe, cfgM[1] & ((cfgM[7] & (otLocal | otRemote)) | fanExp), "alert");
        chkBit(otOe, otLocal | otRemote, "overtemp pin");
        chkBit(fanFaultOe, cfgM[4] & faultIn, "fault pin");
        chkBit(pwmOutOe, cfgM[3] ? ~pwmOn : pwmOn, "pwm pin");
        chkBit(fanIrq, fanExp, "fan irq");
        chkBit(monitorEn, cfgM[0], "start bit");
        chk({11'h0, sdaLvl, pwmLvl, faultLvl, otLvl, alertLvl}, 16'h0, "open drain levels");
    endtask : checkPins

    task automatic randPins();
        @(posedge clk_sys);
        rng = xorshift(rng);
        {pwmOn, faultIn, rangeAlarm, stall, otRemote, otLocal} <= rng[5:0];
        dutyRem <= rng[15:8];
        dutyLoc <= rng[23:16];
        dutySpd <= rng[31:24];
        checkPins();
    endtask : randPins

    // Only mapped places change the model; the spare ones must ignore the write.
    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        logic ok;
        serial_host_model_inst.writeReg(addr, data, ok);
        chkBit(ok, 1'b1, "write ack");
        if (addr === ADDR_CFG) cfgM = data;
        if (addr === ADDR_DUTY) dutyM = data;
        if (addr === ADDR_TGT_LO) tgtM[7:0] = data;
        if (addr === ADDR_TGT_HI) tgtM[15:8] = data;
        repeat (6) @(posedge clk_sys);
    endtask : wr

    task automatic rdChk(input logic [7:0] addr, input logic [7:0] exp);
        logic       ok;
        logic [7:0] d;
        serial_host_model_inst.readReg(addr, d, ok);
        chkBit(ok, 1'b1, "read ack");
        chk({8'h0, d}, {8'h0, exp}, "read data");
    endtask : rdChk

    task automatic results();
        $display("Counts: %0d checked, %0d mismatched", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : results

    // A hung handshake would stall the host tasks; the whole run needs well under this span.
    initial begin
        #1_000_000;
        n_fail++;
        $display("[ERR] %0t watchdog expired", $time);
        results();
    end

    initial begin
        rst_b = 1'b0;
        {pwmOn, faultIn, rangeAlarm, stall, otRemote, otLocal} = 6'h00;
        {dutyRem, dutyLoc, dutySpd} = 24'h0;
        rng = 32'h73F7;
        cfgM = CFG_RESET;
        dutyM = DUTY_RESET;
        tgtM = {TGT_RESET, TGT_RESET};
        serial_host_model_inst.resetClocks();
        repeat (16) @(posedge clk_sys);
        rst_b <= 1'b1;
        // The link reset needs clock edges of its own before it lets go.
        serial_host_model_inst.resetClocks();
        repeat (4) @(posedge clk_sys);
        // Every alert source active while the global enable is still clear after reset.
        {faultIn, rangeAlarm, stall, otRemote, otLocal} <= 5'h1F;
        checkPins();
        chk(speedTarget, tgtM, "target reset");
        rdChk(ADDR_CFG, CFG_RESET);
        rdChk(ADDR_TGT_HI, TGT_RESET);
        $display("Test reset values done");
        wr(ADDR_SPARE_A, 8'hFF);
        rdChk(ADDR_SPARE_A, SPARE_VALUE);
        rdChk(ADDR_SPARE_B, SPARE_VALUE);
        wr(ADDR_DUTY, 8'h5A);
        wr(ADDR_TGT_LO, 8'h34);
        wr(ADDR_TGT_HI, 8'h12);
        chk(speedTarget, tgtM, "target");
        rdChk(ADDR_DUTY, dutyM);
        $display("Test registers done");
        // Each drive selector code with the start bit clear and then set.
        for (int m = 0; m < 8; m++) begin
            wr(ADDR_CFG, {1'b1, m[1:0], 4'b0110, m[2]});
            repeat (3) randPins();
        end
        $display("Test drive modes done");
        for (int i = 0; i < 12; i++) begin
            rng = xorshift(rng);
            wr(ADDR_CFG, rng[7:0]);
            rdChk(ADDR_CFG, cfgM);
            repeat (4) randPins();
        end
        $display("Test random configurations done");
        results();
    end
endmodule : fan_mode_config_and_alert_gating_test
